// ===== cac_params.svh
`ifndef CAC_PARAMS_SVH
`define CAC_PARAMS_SVH

// register byte offsets
`define CAC_ADDR_W 5
`define CAC_OFS_CFG 5'h00
`define CAC_OFS_STAT 5'h04
`define CAC_OFS_OPB 5'h08
`define CAC_OFS_CMD 5'h0c
`define CAC_OFS_RLO 5'h10
`define CAC_OFS_RHI 5'h14

// core_configuration fields
`define CAC_CFG_DL_HI 10
`define CAC_CFG_DL_LO 8
`define CAC_CFG_ACC_A_SATURATION_ENABLE 7
`define CAC_CFG_ACC_B_SATURATION_ENABLE 6
`define CAC_CFG_DATA_WRITE_SATURATION_ENABLE 5
`define CAC_CFG_SATURATION_MODE_SELECT 4
`define CAC_CFG_PRIORITY_LEVEL_MSB 3
`define CAC_CFG_RND 1
`define CAC_CFG_IF 0
`define CAC_CFG_RST_DATA_WRITE_SATURATION_ENABLE 1'h1

// status_word fields
`define CAC_SR_C 0
`define CAC_SR_Z 1
`define CAC_SR_OV 2
`define CAC_SR_N 3
`define CAC_SR_IPL_HI 7
`define CAC_SR_IPL_LO 5
`define CAC_SR_DC 8
`define CAC_SR_WMASK 16'h01ef

// dsp saturation and rounding constants
`define CAC_ACC_MAX40 40'h7fffffffff
`define CAC_ACC_MIN40 40'h8000000000
`define CAC_ACC_MAX32 40'h007fffffff
`define CAC_ACC_MIN32 40'hff80000000
`define CAC_RND_HALF 40'h0000008000
`define CAC_RND_TIE 16'h8000
`define CAC_W_MAX 16'h7fff
`define CAC_W_MIN 16'h8000

`endif

// ===== cac_pkg.sv
package cac_pkg;

    typedef enum logic [3:0] {
        CAC_OP_ADD,
        CAC_OP_ADDC,
        CAC_OP_SUB,
        CAC_OP_SUBB,
        CAC_OP_AND,
        CAC_OP_IOR,
        CAC_OP_XOR,
        CAC_OP_SHL,
        CAC_OP_LSR,
        CAC_OP_ASR,
        CAC_OP_MUL
    } cac_op_e;

    typedef enum logic [2:0] {
        CAC_MUL_SS,
        CAC_MUL_UU,
        CAC_MUL_SLIT,
        CAC_MUL_ULIT,
        CAC_MUL_US,
        CAC_MUL_BYTE
    } cac_mul_e;

    typedef struct packed {
        logic dsp_frac;
        logic [4:0] literal;
        logic [2:0] mul_mode;
        logic dst_mem;
        logic src_mem;
        logic byte_mode;
        logic [3:0] op;
    } cac_cmd_s;

    typedef struct packed {
        logic valid;
        logic sel_b;
        logic [40:0] sum;
    } cac_dsp_s;

endpackage

// ===== cac_alu_core.sv
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "cac_params.svh"

module cac_alu_core (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [`CAC_ADDR_W-1:0] avm_address,
    input wire logic avm_read,
    input wire logic avm_write,
    input wire logic [31:0] avm_writedata,
    output logic [31:0] avm_readdata,
    output logic avm_waitrequest,
    // operand sources
    input wire logic [15:0] wreg_rd_data,
    input wire logic [15:0] dmem_rd_data,
    // result sinks
    output logic wreg_wr_en,
    output logic [15:0] wreg_wr_data,
    output logic dmem_wr_en,
    output logic [15:0] dmem_wr_data,
    // loop and interrupt hardware
    input wire logic [2:0] do_loop_depth,
    input wire logic priority_msb_set,
    output logic [3:0] cpu_priority_level,
    output logic user_int_block,
    // dsp engine
    input wire cac_pkg::cac_dsp_s dsp_acc_in,
    input wire logic dsp_store,
    input wire logic dsp_store_sel_b,
    output logic [39:0] first_accumulator,
    output logic [39:0] second_accumulator,
    output logic [2:0] dsp_mode
);

    logic waitreq_ff;
    logic [31:0] rdata_ff;
    logic [2:0] do_loop_depth_ff;
    logic acc_a_saturation_enable_ff;
    logic acc_b_saturation_enable_ff;
    logic data_write_saturation_enable_ff;
    logic saturation_mode_select_ff;
    logic priority_level_msb_ff;
    logic rounding_select_ff;
    logic int_frac_ff;
    logic [15:0] status_word_ff;
    logic [15:0] opb_ff;
    cac_pkg::cac_cmd_s cmd_ff;
    logic [15:0] res_lo_ff;
    logic [15:0] res_hi_ff;
    logic wreg_wr_en_ff;
    logic [15:0] wreg_wr_data_ff;
    logic dmem_wr_en_ff;
    logic [15:0] dmem_wr_data_ff;
    logic [39:0] acc_a_ff;
    logic [39:0] acc_b_ff;
    logic [3:0] prio_ff;
    logic blk_ff;

    logic take;
    logic wr_take;
    logic cmd_go;
    logic [15:0] core_configuration;
    logic [31:0] nxt_rdata;
    cac_pkg::cac_cmd_s new_cmd;
    cac_pkg::cac_op_e op;
    logic [15:0] opa;
    logic [15:0] opb;
    logic [15:0] nxt_res_lo;
    logic [15:0] nxt_res_hi;
    logic [15:0] nxt_status;
    logic [39:0] nxt_acc;
    logic [15:0] nxt_dsp_word;

    assign take = (avm_read | avm_write) & ~waitreq_ff;
    assign wr_take = avm_write & ~waitreq_ff;
    assign cmd_go = wr_take & (avm_address == `CAC_OFS_CMD);
    assign new_cmd = cac_pkg::cac_cmd_s'(avm_writedata[15:0]);
    assign op = cac_pkg::cac_op_e'(new_cmd.op);

    // bus handshake: one wait cycle, answer on the second edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            waitreq_ff <= 1'h1;
        end else begin
            waitreq_ff <= ~((avm_read | avm_write) & waitreq_ff);
        end
    end

    always_comb begin
        core_configuration = 16'h0000;
        core_configuration[`CAC_CFG_DL_HI:`CAC_CFG_DL_LO] = do_loop_depth_ff;
        core_configuration[`CAC_CFG_ACC_A_SATURATION_ENABLE] = acc_a_saturation_enable_ff;
        core_configuration[`CAC_CFG_ACC_B_SATURATION_ENABLE] = acc_b_saturation_enable_ff;
        core_configuration[`CAC_CFG_DATA_WRITE_SATURATION_ENABLE] = data_write_saturation_enable_ff;
        core_configuration[`CAC_CFG_SATURATION_MODE_SELECT] = saturation_mode_select_ff;
        core_configuration[`CAC_CFG_PRIORITY_LEVEL_MSB] = priority_level_msb_ff;
        core_configuration[`CAC_CFG_RND] = rounding_select_ff;
        core_configuration[`CAC_CFG_IF] = int_frac_ff;
    end

    always_comb begin
        nxt_rdata = 32'h00000000;
        case (avm_address)
            `CAC_OFS_CFG: nxt_rdata[15:0] = core_configuration;
            `CAC_OFS_STAT: nxt_rdata[15:0] = status_word_ff;
            `CAC_OFS_OPB: nxt_rdata[15:0] = opb_ff;
            `CAC_OFS_CMD: nxt_rdata[15:0] = cmd_ff;
            `CAC_OFS_RLO: nxt_rdata[15:0] = res_lo_ff;
            `CAC_OFS_RHI: nxt_rdata[15:0] = res_hi_ff;
            default: nxt_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= 32'h00000000;
        end else if ((avm_read | avm_write) & waitreq_ff) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // loop depth follows the loop hardware
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            do_loop_depth_ff <= 3'h0;
        end else begin
            do_loop_depth_ff <= do_loop_depth;
        end
    end

    // writable configuration bits
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_a_saturation_enable_ff <= 1'h0;
            acc_b_saturation_enable_ff <= 1'h0;
            data_write_saturation_enable_ff <= `CAC_CFG_RST_DATA_WRITE_SATURATION_ENABLE;
            saturation_mode_select_ff <= 1'h0;
            rounding_select_ff <= 1'h0;
            int_frac_ff <= 1'h0;
        end else if (wr_take & (avm_address == `CAC_OFS_CFG)) begin
            acc_a_saturation_enable_ff <= avm_writedata[`CAC_CFG_ACC_A_SATURATION_ENABLE];
            acc_b_saturation_enable_ff <= avm_writedata[`CAC_CFG_ACC_B_SATURATION_ENABLE];
            data_write_saturation_enable_ff <= avm_writedata[`CAC_CFG_DATA_WRITE_SATURATION_ENABLE];
            saturation_mode_select_ff <= avm_writedata[`CAC_CFG_SATURATION_MODE_SELECT];
            rounding_select_ff <= avm_writedata[`CAC_CFG_RND];
            int_frac_ff <= avm_writedata[`CAC_CFG_IF];
        end
    end

    // priority msb: hardware sets, software may only clear, set wins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            priority_level_msb_ff <= 1'h0;
        end else if (priority_msb_set) begin
            priority_level_msb_ff <= 1'h1;
        end else if (wr_take & (avm_address == `CAC_OFS_CFG) & ~avm_writedata[`CAC_CFG_PRIORITY_LEVEL_MSB]) begin
            priority_level_msb_ff <= 1'h0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prio_ff <= 4'h0;
            blk_ff <= 1'h0;
        end else begin
            prio_ff <= {priority_level_msb_ff,
                status_word_ff[`CAC_SR_IPL_HI:`CAC_SR_IPL_LO]};
            blk_ff <= priority_level_msb_ff;
        end
    end

    // alu datapath
    always_comb begin
        logic [15:0] bm;
        logic cin;
        logic [16:0] s17;
        logic [8:0] s9;
        logic [4:0] nib;
        logic [16:0] ma;
        logic [16:0] mb;
        logic [33:0] prod;
        logic msb_a;
        logic msb_b;
        logic msb_r;
        logic byt;
        bm = 16'h0000;
        cin = 1'h0;
        s17 = 17'h00000;
        s9 = 9'h000;
        nib = 5'h00;
        ma = 17'h00000;
        mb = 17'h00000;
        prod = 34'h000000000;
        msb_a = 1'h0;
        msb_b = 1'h0;
        msb_r = 1'h0;
        byt = new_cmd.byte_mode;
        opa = new_cmd.src_mem ? dmem_rd_data : wreg_rd_data;
        opb = opb_ff;
        nxt_res_lo = res_lo_ff;
        nxt_res_hi = res_hi_ff;
        nxt_status = status_word_ff;
        case (op)
            cac_pkg::CAC_OP_ADD, cac_pkg::CAC_OP_ADDC, cac_pkg::CAC_OP_SUB,
            cac_pkg::CAC_OP_SUBB: begin
                // subtract adds the complement; carry means no borrow
                bm = (op == cac_pkg::CAC_OP_SUB || op == cac_pkg::CAC_OP_SUBB) ? ~opb : opb;
                case (op)
                    cac_pkg::CAC_OP_SUB: cin = 1'h1;
                    cac_pkg::CAC_OP_ADDC, cac_pkg::CAC_OP_SUBB: cin = status_word_ff[`CAC_SR_C];
                    default: cin = 1'h0;
                endcase
                s17 = {1'h0, opa} + {1'h0, bm} + {16'h0000, cin};
                s9 = {1'h0, opa[7:0]} + {1'h0, bm[7:0]} + {8'h00, cin};
                nib = {1'h0, opa[3:0]} + {1'h0, bm[3:0]} + {4'h0, cin};
                nxt_res_lo = byt ? {opa[15:8], s9[7:0]} : s17[15:0];
                msb_a = byt ? opa[7] : opa[15];
                msb_b = byt ? bm[7] : bm[15];
                msb_r = byt ? s9[7] : s17[15];
                nxt_status[`CAC_SR_C] = byt ? s9[8] : s17[16];
                nxt_status[`CAC_SR_DC] = nib[4];
                nxt_status[`CAC_SR_OV] = (msb_a == msb_b) & (msb_r != msb_a);
            end
            cac_pkg::CAC_OP_AND: nxt_res_lo = opa & opb;
            cac_pkg::CAC_OP_IOR: nxt_res_lo = opa | opb;
            cac_pkg::CAC_OP_XOR: nxt_res_lo = opa ^ opb;
            cac_pkg::CAC_OP_SHL: begin
                nxt_res_lo = {opa[14:0], 1'h0};
                nxt_status[`CAC_SR_C] = byt ? opa[7] : opa[15];
            end
            cac_pkg::CAC_OP_LSR: begin
                nxt_res_lo = byt ? {opa[15:8], 1'h0, opa[7:1]} : {1'h0, opa[15:1]};
                nxt_status[`CAC_SR_C] = opa[0];
            end
            cac_pkg::CAC_OP_ASR: begin
                nxt_res_lo = byt ? {opa[15:8], opa[7], opa[7:1]} : {opa[15], opa[15:1]};
                nxt_status[`CAC_SR_C] = opa[0];
            end
            cac_pkg::CAC_OP_MUL: begin
                // all modes share one signed 17x17 multiplier
                case (cac_pkg::cac_mul_e'(new_cmd.mul_mode))
                    cac_pkg::CAC_MUL_SS: begin
                        ma = {opa[15], opa};
                        mb = {opb[15], opb};
                    end
                    cac_pkg::CAC_MUL_US: begin
                        ma = {1'h0, opa};
                        mb = {opb[15], opb};
                    end
                    cac_pkg::CAC_MUL_SLIT: begin
                        ma = {opa[15], opa};
                        mb = {12'h000, new_cmd.literal};
                    end
                    cac_pkg::CAC_MUL_ULIT: begin
                        ma = {1'h0, opa};
                        mb = {12'h000, new_cmd.literal};
                    end
                    cac_pkg::CAC_MUL_BYTE: begin
                        ma = {9'h000, opa[7:0]};
                        mb = {9'h000, opb[7:0]};
                    end
                    default: begin
                        ma = {1'h0, opa};
                        mb = {1'h0, opb};
                    end
                endcase
                prod = 34'($signed(ma) * $signed(mb));
                if (new_cmd.dsp_frac & ~int_frac_ff) begin
                    prod = {prod[32:0], 1'h0};
                end
                nxt_res_lo = prod[15:0];
                nxt_res_hi = (cac_pkg::cac_mul_e'(new_cmd.mul_mode) == cac_pkg::CAC_MUL_BYTE) ?
                    16'h0000 : prod[31:16];
            end
            default: nxt_res_lo = res_lo_ff;
        endcase
        if (op != cac_pkg::CAC_OP_MUL) begin
            nxt_status[`CAC_SR_N] = byt ? nxt_res_lo[7] : nxt_res_lo[15];
            nxt_status[`CAC_SR_Z] = byt ? (nxt_res_lo[7:0] == 8'h00) :
                (nxt_res_lo == 16'h0000);
        end
    end

    // software registers and alu results
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_word_ff <= 16'h0000;
            opb_ff <= 16'h0000;
            cmd_ff <= '0;
            res_lo_ff <= 16'h0000;
            res_hi_ff <= 16'h0000;
        end else begin
            if (wr_take & (avm_address == `CAC_OFS_STAT)) begin
                status_word_ff <= avm_writedata[15:0] & `CAC_SR_WMASK;
            end else if (cmd_go) begin
                status_word_ff <= nxt_status;
            end
            if (wr_take & (avm_address == `CAC_OFS_OPB)) begin
                opb_ff <= avm_writedata[15:0];
            end
            if (cmd_go) begin
                cmd_ff <= new_cmd;
                res_lo_ff <= nxt_res_lo;
                res_hi_ff <= nxt_res_hi;
            end
        end
    end

    // accumulator saturation
    always_comb begin
        logic en;
        en = dsp_acc_in.sel_b ? acc_b_saturation_enable_ff : acc_a_saturation_enable_ff;
        nxt_acc = dsp_acc_in.sum[39:0];
        if (en & saturation_mode_select_ff & (dsp_acc_in.sum[40] != dsp_acc_in.sum[39])) begin
            nxt_acc = dsp_acc_in.sum[40] ? `CAC_ACC_MIN40 : `CAC_ACC_MAX40;
        end else if (en & ~saturation_mode_select_ff &
            (dsp_acc_in.sum[40:31] != {10{dsp_acc_in.sum[40]}})) begin
            nxt_acc = dsp_acc_in.sum[40] ? `CAC_ACC_MIN32 : `CAC_ACC_MAX32;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_a_ff <= 40'h0000000000;
            acc_b_ff <= 40'h0000000000;
        end else if (dsp_acc_in.valid) begin
            if (dsp_acc_in.sel_b) begin
                acc_b_ff <= nxt_acc;
            end else begin
                acc_a_ff <= nxt_acc;
            end
        end
    end

    // dsp store: round then optionally saturate to one word
    always_comb begin
        logic [39:0] src;
        logic [39:0] rnd;
        src = dsp_store_sel_b ? acc_b_ff : acc_a_ff;
        if (rounding_select_ff | (src[15:0] != `CAC_RND_TIE) | src[16]) begin
            rnd = src + `CAC_RND_HALF;
        end else begin
            rnd = src;
        end
        nxt_dsp_word = rnd[31:16];
        if (data_write_saturation_enable_ff & (rnd[39:31] != {9{rnd[39]}})) begin
            nxt_dsp_word = rnd[39] ? `CAC_W_MIN : `CAC_W_MAX;
        end
    end

    // result write ports
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wreg_wr_en_ff <= 1'h0;
            wreg_wr_data_ff <= 16'h0000;
            dmem_wr_en_ff <= 1'h0;
            dmem_wr_data_ff <= 16'h0000;
        end else begin
            wreg_wr_en_ff <= cmd_go & ~new_cmd.dst_mem;
            dmem_wr_en_ff <= (cmd_go & new_cmd.dst_mem) | (dsp_store & ~cmd_go);
            if (cmd_go) begin
                wreg_wr_data_ff <= nxt_res_lo;
                dmem_wr_data_ff <= nxt_res_lo;
            end else if (dsp_store) begin
                dmem_wr_data_ff <= nxt_dsp_word;
            end
        end
    end

    assign avm_waitrequest = waitreq_ff;
    assign avm_readdata = rdata_ff;
    assign wreg_wr_en = wreg_wr_en_ff;
    assign wreg_wr_data = wreg_wr_data_ff;
    assign dmem_wr_en = dmem_wr_en_ff;
    assign dmem_wr_data = dmem_wr_data_ff;
    assign cpu_priority_level = prio_ff;
    assign user_int_block = blk_ff;
    assign first_accumulator = acc_a_ff;
    assign second_accumulator = acc_b_ff;
    assign dsp_mode = {int_frac_ff, rounding_select_ff, saturation_mode_select_ff};

endmodule

`default_nettype wire

// ===== cac_alu_core_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "cac_params.svh"
module cac_alu_core_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register bus
    input wire logic [`CAC_ADDR_W-1:0] avm_address,
    input wire logic avm_read,
    input wire logic avm_write,
    input wire logic [31:0] avm_writedata,
    input wire logic [31:0] avm_readdata,
    input wire logic avm_waitrequest,
    // operands and results
    input wire logic [15:0] wreg_rd_data,
    input wire logic [15:0] dmem_rd_data,
    input wire logic wreg_wr_en,
    input wire logic [15:0] wreg_wr_data,
    input wire logic dmem_wr_en,
    input wire logic [15:0] dmem_wr_data,
    // loop, interrupt and dsp
    input wire logic [2:0] do_loop_depth,
    input wire logic priority_msb_set,
    input wire logic [3:0] cpu_priority_level,
    input wire logic user_int_block,
    input wire cac_pkg::cac_dsp_s dsp_acc_in,
    input wire logic dsp_store,
    input wire logic dsp_store_sel_b,
    input wire logic [39:0] first_accumulator,
    input wire logic [39:0] second_accumulator,
    input wire logic [2:0] dsp_mode
);
    logic cmd_go;
    logic cfg_go;
    logic cmd_wreg;
    assign cmd_go = avm_write && !avm_waitrequest && avm_address == `CAC_OFS_CMD;
    assign cfg_go = avm_write && !avm_waitrequest && avm_address == `CAC_OFS_CFG;
    assign cmd_wreg = cmd_go && !avm_writedata[6];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_req; (avm_read || avm_write) && avm_waitrequest; endsequence
    sequence s_ack; !avm_waitrequest ##1 avm_waitrequest; endsequence
    property p_bus; s_req |=> s_ack; endproperty
    a_bus: assert property (p_bus) else $error("bus answer not one wait cycle");
    property p_join; cpu_priority_level[3] == user_int_block; endproperty
    a_join: assert property (p_join) else $error("priority msb mismatch");
    property p_set; priority_msb_set |-> ##2 user_int_block; endproperty
    a_set: assert property (p_set) else $error("msb set not seen");
    property p_rise; $rose(user_int_block) |-> $past(priority_msb_set, 2); endproperty
    a_rise: assert property (p_rise) else $error("msb set without cause");
    property p_wcause; wreg_wr_en |-> $past(cmd_wreg) ##1 !wreg_wr_en; endproperty
    a_wcause: assert property (p_wcause) else $error("register write wrong");
    property p_dalu; cmd_go && avm_writedata[6] |=> dmem_wr_en && !wreg_wr_en; endproperty
    a_dalu: assert property (p_dalu) else $error("memory result missing");
    property p_store; dsp_store && !cmd_go |=> dmem_wr_en; endproperty
    a_store: assert property (p_store) else $error("dsp store missing");
    property p_hold;
        !dsp_acc_in.valid |=> $stable(first_accumulator) && $stable(second_accumulator);
    endproperty
    a_hold: assert property (p_hold) else $error("accumulator moved");
    property p_lda; dsp_acc_in.valid && !dsp_acc_in.sel_b |=> $stable(second_accumulator); endproperty
    a_lda: assert property (p_lda) else $error("wrong accumulator loaded");
    property p_mode; $changed(dsp_mode) |-> $past(cfg_go) || $past(cfg_go, 2); endproperty
    a_mode: assert property (p_mode) else $error("dsp mode moved alone");
endmodule
bind cac_alu_core cac_alu_core_checker u_cac_alu_core_checker (.ref_clk, .rst, .avm_address,
    .avm_read, .avm_write, .avm_writedata, .avm_readdata, .avm_waitrequest, .wreg_rd_data,
    .dmem_rd_data, .wreg_wr_en, .wreg_wr_data, .dmem_wr_en, .dmem_wr_data, .do_loop_depth,
    .priority_msb_set, .cpu_priority_level, .user_int_block, .dsp_acc_in, .dsp_store,
    .dsp_store_sel_b, .first_accumulator, .second_accumulator, .dsp_mode);
`default_nettype wire

// ===== cac_far_side.sv
`timescale 1ns/100ps
`default_nettype none
module cac_far_side (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // preload
    input wire logic ld,
    input wire logic [15:0] ld_data,
    // result sinks
    input wire logic wreg_wr_en,
    input wire logic [15:0] wreg_wr_data,
    input wire logic dmem_wr_en,
    input wire logic [15:0] dmem_wr_data,
    // operand sources
    output logic [15:0] wreg_rd_data,
    output logic [15:0] dmem_rd_data
);
    logic [15:0] w_ff;
    logic [15:0] m_ff;
    // memory word preloads inverted so a wrong source shows
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            w_ff <= 16'h0000;
            m_ff <= 16'hffff;
        end else if (ld) begin
            w_ff <= ld_data;
            m_ff <= ~ld_data;
        end else begin
            if (wreg_wr_en) w_ff <= wreg_wr_data;
            if (dmem_wr_en) m_ff <= dmem_wr_data;
        end
    end
    assign wreg_rd_data = w_ff;
    assign dmem_rd_data = m_ff;
endmodule
`default_nettype wire

// ===== test_core_alu_and_dsp_mode_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "cac_params.svh"
`define CHK(nm, e, s) begin \
    total_checks++; \
    if ((s) !== (e)) begin \
        fails++; \
        $display("[FAIL] %s exp %h got %h", nm, e, s); \
    end \
end
module test_core_alu_and_dsp_mode_control;
    logic ref_clk, rst, avm_read, avm_write, avm_waitrequest, wreg_wr_en, dmem_wr_en, ld;
    logic priority_msb_set, user_int_block, dsp_store, dsp_store_sel_b;
    logic [4:0] avm_address;
    logic [31:0] avm_writedata, avm_readdata, rdata;
    logic [15:0] wreg_rd_data, dmem_rd_data, wreg_wr_data, dmem_wr_data, ld_data;
    logic [2:0] do_loop_depth, dsp_mode;
    logic [3:0] cpu_priority_level;
    logic [39:0] first_accumulator, second_accumulator;
    cac_pkg::cac_dsp_s dsp_acc_in;
    int fails = 0;
    int total_checks = 0;
    logic [15:0] ta [11] = '{16'h7fff, 16'h0000, 16'h0005, 16'hf0f0, 16'h12ff, 16'hffff,
        16'hffff, 16'hfffe, 16'hfffe, 16'hffff, 16'h12ff};
    logic [15:0] tb [11] = '{16'h0001, 16'h0001, 16'h0005, 16'h0ff0, 16'h0001, 16'h0002,
        16'h0002, 16'h0000, 16'h0000, 16'hffff, 16'h3402};
    logic [15:0] tc [11] = '{16'h0000, 16'h0022, 16'h0042, 16'h0004, 16'h0010, 16'h000a,
        16'h008a, 16'h7d0a, 16'h7d8a, 16'h020a, 16'h028a};
    logic [15:0] tr [11] = '{16'h8000, 16'hffff, 16'h0000, 16'h00f0, 16'h1200, 16'hfffe,
        16'hfffe, 16'hffc2, 16'hffc2, 16'h0001, 16'h01fe};
    logic [15:0] tx [11] = '{16'h010c, 16'h0008, 16'h0103, 16'h0000, 16'h0103, 16'hffff,
        16'h0001, 16'hffff, 16'h001e, 16'hffff, 16'h0000};
    cac_alu_core u_cac_alu_core (.ref_clk, .rst, .avm_address, .avm_read, .avm_write,
        .avm_writedata, .avm_readdata, .avm_waitrequest, .wreg_rd_data, .dmem_rd_data,
        .wreg_wr_en, .wreg_wr_data, .dmem_wr_en, .dmem_wr_data, .do_loop_depth,
        .priority_msb_set, .cpu_priority_level, .user_int_block, .dsp_acc_in, .dsp_store,
        .dsp_store_sel_b, .first_accumulator, .second_accumulator, .dsp_mode);
    cac_far_side u_cac_far_side (.ref_clk, .rst, .ld, .ld_data, .wreg_wr_en, .wreg_wr_data,
        .dmem_wr_en, .dmem_wr_data, .wreg_rd_data, .dmem_rd_data);
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic finish_test();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d);
        int n;
        @(posedge ref_clk);
        avm_address <= a;
        avm_write <= wr;
        avm_read <= !wr;
        avm_writedata <= {16'h0000, d};
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avm_waitrequest !== 1'b0 && n < 50);
        if (n < 50) begin
            rdata = avm_readdata;
            avm_read <= 1'b0;
            avm_write <= 1'b0;
        end else begin
            fails++;
            finish_test();
        end
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] e, input string nm);
        bus(1'b0, a, 16'h0000);
        `CHK(nm, {16'h0000, e}, rdata)
    endtask
    task automatic t_reset();
        rd_chk(`CAC_OFS_CFG, 16'h0020, "cfg reset");
        rd_chk(5'h1c, 16'h0000, "unmapped");
    endtask
    task automatic t_cfg();
        do_loop_depth <= 3'h7;
        bus(1'b1, `CAC_OFS_CFG, 16'hffff);
        rd_chk(`CAC_OFS_CFG, 16'h07f3, "cfg ones");
        `CHK("mode ones", 3'h7, dsp_mode)
        do_loop_depth <= 3'h0;
        bus(1'b1, `CAC_OFS_CFG, 16'h0000);
        rd_chk(`CAC_OFS_CFG, 16'h0000, "cfg zeros");
        `CHK("mode zeros", 3'h0, dsp_mode)
    endtask
    task automatic t_prio();
        @(posedge ref_clk);
        priority_msb_set <= 1'b1;
        @(posedge ref_clk);
        priority_msb_set <= 1'b0;
        bus(1'b1, `CAC_OFS_STAT, 16'h00a0);
        tick(2);
        `CHK("level set", 4'hd, cpu_priority_level)
        `CHK("block set", 1'b1, user_int_block)
        bus(1'b1, `CAC_OFS_CFG, 16'h0000);
        bus(1'b1, `CAC_OFS_CFG, 16'h0008);
        rd_chk(`CAC_OFS_CFG, 16'h0000, "msb no set");
        `CHK("level clr", 4'h5, cpu_priority_level)
        `CHK("block clr", 1'b0, user_int_block)
    endtask
    task automatic t_alu();
        for (int i = 0; i < 11; i++) begin
            @(posedge ref_clk);
            ld <= 1'b1;
            ld_data <= tc[i][5] ? ~ta[i] : ta[i];
            @(posedge ref_clk);
            ld <= 1'b0;
            bus(1'b1, `CAC_OFS_STAT, 16'h0000);
            bus(1'b1, `CAC_OFS_OPB, tb[i]);
            bus(1'b1, `CAC_OFS_CMD, tc[i]);
            tick(2);
            `CHK("dest", tr[i], tc[i][6] ? dmem_rd_data : wreg_rd_data)
            rd_chk(`CAC_OFS_RLO, tr[i], "result");
            if (i < 5) rd_chk(`CAC_OFS_STAT, tx[i], "flags");
            else rd_chk(`CAC_OFS_RHI, tx[i], "product hi");
        end
    endtask
    task automatic ld_acc(input logic sel, input logic [40:0] sum);
        @(posedge ref_clk);
        dsp_acc_in <= {1'b1, sel, sum};
    endtask
    task automatic store_b(input logic [15:0] e);
        @(posedge ref_clk);
        dsp_store <= 1'b1;
        dsp_store_sel_b <= 1'b1;
        @(posedge ref_clk);
        dsp_store <= 1'b0;
        tick(2);
        `CHK("store", e, dmem_rd_data)
    endtask
    task automatic t_dsp();
        bus(1'b1, `CAC_OFS_CFG, 16'h00a0);
        ld_acc(1'b0, 41'h00080000000);
        ld_acc(1'b1, 41'h00080000000);
        @(posedge ref_clk);
        dsp_acc_in <= '0;
        tick(1);
        `CHK("acc a 32", `CAC_ACC_MAX32, first_accumulator)
        `CHK("acc b off", 40'h0080000000, second_accumulator)
        bus(1'b1, `CAC_OFS_CFG, 16'h00d0);
        ld_acc(1'b0, 41'h08000000000);
        ld_acc(1'b1, 41'h00080000000);
        @(posedge ref_clk);
        dsp_acc_in <= '0;
        tick(1);
        `CHK("acc a 40", `CAC_ACC_MAX40, first_accumulator)
        `CHK("acc b 40", 40'h0080000000, second_accumulator)
        store_b(16'h8000);
        bus(1'b1, `CAC_OFS_CFG, 16'h00f0);
        store_b(`CAC_W_MAX);
    endtask
    initial begin
        rst = 1'b1;
        {avm_read, avm_write, ld, priority_msb_set, dsp_store, dsp_store_sel_b} = '0;
        avm_address = 5'h00;
        avm_writedata = 32'h00000000;
        ld_data = 16'h0000;
        do_loop_depth = 3'h0;
        dsp_acc_in = '0;
        tick(3);
        rst <= 1'b0;
        t_reset();
        t_cfg();
        t_prio();
        t_alu();
        t_dsp();
        finish_test();
    end
endmodule
`default_nettype wire
